// *** hdl/fsprw_ctrl.sv ***
// Function
// - Ignore store instruction fetched from application part
// - Start programming only from boot part fetch
// - Boot code may program any page
// - Boot border set by boot size fuses
// - Application lock pair guards application part
// - Boot lock pair guards boot part
// - Fixed border between rewrite and halt regions
// - Rewrite region programming keeps other reads working
// - Halt region programming stalls the CPU
// - No valid rewrite region data while programming
// - Boot part always inside halt region
// - Busy flag reads one while reads blocked
//
// Our own choices: the strobed register port and the address map.
`timescale 1ns/1ps
module fsprw_ctrl
    import fsprw_pkg::*;
#(
    parameter int unsigned PROG_CYCLES = fsprw_pkg::PROG_CYC
) (
    input  wire logic                 ref_clk,
    input  wire logic                 srst,
    input  wire logic [7:0]           reg_addr,
    input  wire logic [7:0]           reg_wdata,
    input  wire logic                 reg_we,
    input  wire logic                 reg_re,
    output logic [7:0]                reg_rdata,
    input  wire logic [1:0]           boot_size_fuses,
    input  wire logic [1:0]           application_lock_pair,
    input  wire logic [1:0]           boot_lock_pair,
    input  wire logic                 spm_req,
    input  wire logic [15:0]          spm_fetch_addr,
    input  wire logic [15:0]          spm_target_addr,
    input  wire logic [15:0]          spm_data,
    input  wire logic                 cpu_rd_req,
    input  wire logic [15:0]          cpu_rd_addr,
    input  wire logic [15:0]          cpu_rd_from,
    input  wire logic [15:0]          flash_rd_data,
    output logic [15:0]               cpu_rd_data,
    output logic                      cpu_rd_valid,
    output logic                      cpu_halt,
    output logic                      spm_done,
    output logic                      buf_wr_en,
    output logic [6:0]                buf_word_addr,
    output logic [15:0]               buf_wr_data,
    output logic                      buf_clear,
    output logic                      flash_erase_start,
    output logic                      flash_write_start,
    output logic [8:0]                flash_page_addr,
    output logic                      rww_read_block
);
    import fsprw_pkg::*;

    // *****************************************************************
    // Declarations
    // *****************************************************************
    fsprw_state_type state_ff, nxt_state;
    logic [5:0]  fuse_meta_ff, fuse_ff;
    logic [5:0]  cmd_ff, nxt_cmd;
    logic [2:0]  win_ff, nxt_win;
    logic        ie_ff, rww_busy_ff, nxt_rww_busy;
    logic        halt_ff, done_ff;
    logic [7:0]  rdata_ff;
    logic [15:0] rd_data_ff;
    logic        rd_valid_ff;
    logic        bwr_ff, bclr_ff, ers_ff, wrt_ff;
    logic [6:0]  bword_ff;
    logic [15:0] bdata_ff;
    logic [8:0]  page_ff;
    logic [15:0] boot_start;
    logic        fetch_boot, fetch_no_read_while_write_region, tgt_boot, tgt_no_read_while_write_region;
    logic        rd_boot, rd_no_read_while_write_region, from_boot, from_no_read_while_write_region;
    logic        op_busy, op_done, op_start;

    function automatic logic fsprw_is_arm(input logic [5:0] c);
        fsprw_is_arm = (c == CMD_LOAD) || (c == CMD_ERASE) || (c == CMD_WRITE);
    endfunction

    function automatic logic fsprw_is_prog(input logic [5:0] c);
        fsprw_is_prog = (c == CMD_ERASE) || (c == CMD_WRITE);
    endfunction

    // *****************************************************************
    // Fuse and lock pin synchroniser
    // *****************************************************************
    // Pins come from outside the clock domain, two stages before use
    always_ff @(posedge ref_clk) begin
        if (srst) begin
            fuse_meta_ff <= 6'h3F;
            fuse_ff      <= 6'h3F;
        end else begin
            fuse_meta_ff <= {boot_lock_pair, application_lock_pair, boot_size_fuses};
            fuse_ff      <= fuse_meta_ff;
        end
    end

    // *****************************************************************
    // Region decode
    // *****************************************************************
    // Largest boot part still starts at the fixed halt border
    assign boot_start = (fuse_ff[1:0] == 2'h0) ? BOOT_START_0 :
                        (fuse_ff[1:0] == 2'h1) ? BOOT_START_1 :
                        (fuse_ff[1:0] == 2'h2) ? BOOT_START_2 : BOOT_START_3;

    fsprw_region_map u_map_fetch (
        .addr       (spm_fetch_addr),
        .boot_start (boot_start),
        .in_boot    (fetch_boot),
        .in_no_read_while_write_region    (fetch_no_read_while_write_region)
    );
    fsprw_region_map u_map_tgt (
        .addr       (spm_target_addr),
        .boot_start (boot_start),
        .in_boot    (tgt_boot),
        .in_no_read_while_write_region    (tgt_no_read_while_write_region)
    );
    fsprw_region_map u_map_rd (
        .addr       (cpu_rd_addr),
        .boot_start (boot_start),
        .in_boot    (rd_boot),
        .in_no_read_while_write_region    (rd_no_read_while_write_region)
    );
    fsprw_region_map u_map_from (
        .addr       (cpu_rd_from),
        .boot_start (boot_start),
        .in_boot    (from_boot),
        .in_no_read_while_write_region    (from_no_read_while_write_region)
    );

    // *****************************************************************
    // Command acceptance
    // *****************************************************************
    logic ctrl_wr, arm_wr, reen_wr, spm_take, lock_ok, tgt_in_app;
    logic cross_rd_ok, rd_ok, in_prog;

    assign in_prog  = (state_ff == ST_PROG_RWW) || (state_ff == ST_PROG_NO_READ_WHILE_WRITE_REGION);
    assign ctrl_wr  = reg_we && (reg_addr == REG_CTRL_ADDR);
    // Writes while programming are dropped, the command is already latched
    assign arm_wr   = ctrl_wr && !in_prog && reg_wdata[CTRL_EN_BIT]
                      && fsprw_is_arm(reg_wdata[5:0]);
    assign reen_wr  = ctrl_wr && !in_prog && (reg_wdata[5:0] == CMD_REEN);
    // Only a store fetched from the boot part is acted on
    assign spm_take = (state_ff == ST_ARMED) && spm_req && fetch_boot;
    // Any page is a legal target, the matching lock pair decides
    assign tgt_in_app = !tgt_boot;
    assign lock_ok  = tgt_in_app ? fuse_ff[2 + LOCK_WR_BIT]
                                 : fuse_ff[4 + LOCK_WR_BIT];
    assign op_start = spm_take && fsprw_is_prog(cmd_ff) && lock_ok;

    fsprw_op_timer #(
        .CYCLES (PROG_CYCLES)
    ) u_timer (
        .ref_clk (ref_clk),
        .srst    (srst),
        .start   (op_start),
        .busy    (op_busy),
        .done    (op_done)
    );

    // *****************************************************************
    // Sequencer next state
    // *****************************************************************
    always_comb begin
        nxt_state = state_ff;
        nxt_cmd   = cmd_ff;
        nxt_win   = win_ff;
        unique case (state_ff)
            ST_IDLE: begin
                if (arm_wr) begin
                    nxt_state = ST_ARMED;
                    nxt_cmd   = reg_wdata[5:0];
                    nxt_win   = SPM_WIN_CYC;
                end
            end
            ST_ARMED: begin
                if (spm_take) begin
                    // Halt region target stalls, rewrite region runs on
                    nxt_state = !op_start ? ST_IDLE :
                                (tgt_no_read_while_write_region ? ST_PROG_NO_READ_WHILE_WRITE_REGION : ST_PROG_RWW);
                    nxt_cmd   = op_start ? cmd_ff : CMD_NONE;
                    nxt_win   = 3'h0;
                end else if (arm_wr) begin
                    nxt_cmd   = reg_wdata[5:0];
                    nxt_win   = SPM_WIN_CYC;
                end else if (win_ff == 3'h1) begin
                    // Store too late: the pattern lapses
                    nxt_state = ST_IDLE;
                    nxt_cmd   = CMD_NONE;
                    nxt_win   = 3'h0;
                end else begin
                    nxt_win   = win_ff - 3'h1;
                end
            end
            ST_PROG_RWW, ST_PROG_NO_READ_WHILE_WRITE_REGION: begin
                if (op_done) begin
                    nxt_state = ST_IDLE;
                    nxt_cmd   = CMD_NONE;
                end
            end
        endcase
    end

    // Set wins over a software clear in the same cycle
    assign nxt_rww_busy = (op_start && !tgt_no_read_while_write_region) ? 1'b1 :
                          (reen_wr ? 1'b0 : rww_busy_ff);

    always_ff @(posedge ref_clk) begin
        if (srst) begin
            state_ff    <= ST_IDLE;
            cmd_ff      <= CMD_NONE;
            win_ff      <= 3'h0;
            rww_busy_ff <= 1'b0;
            ie_ff       <= CTRL_RST[CTRL_IE_BIT];
        end else begin
            state_ff    <= nxt_state;
            cmd_ff      <= nxt_cmd;
            win_ff      <= nxt_win;
            rww_busy_ff <= nxt_rww_busy;
            ie_ff       <= (ctrl_wr && !in_prog) ? reg_wdata[CTRL_IE_BIT] : ie_ff;
        end
    end

    // *****************************************************************
    // CPU halt, completion and flash strobes
    // *****************************************************************
    // Halt lifts with the done pulse so the next instruction runs
    always_ff @(posedge ref_clk) begin
        if (srst) begin
            halt_ff <= 1'b0;
            done_ff <= 1'b0;
            bwr_ff  <= 1'b0;
            bclr_ff <= 1'b0;
            ers_ff  <= 1'b0;
            wrt_ff  <= 1'b0;
            page_ff <= 9'h000;
            bword_ff <= 7'h00;
            bdata_ff <= 16'h0000;
        end else begin
            halt_ff <= (op_start && tgt_no_read_while_write_region) ? 1'b1 :
                       (op_done ? 1'b0 : halt_ff);
            done_ff <= (spm_req && !(op_start && tgt_no_read_while_write_region) && !halt_ff)
                       || (op_done && (state_ff == ST_PROG_NO_READ_WHILE_WRITE_REGION));
            bwr_ff  <= spm_take && (cmd_ff == CMD_LOAD);
            bclr_ff <= reen_wr || (op_done && (cmd_ff == CMD_WRITE));
            ers_ff  <= op_start && (cmd_ff == CMD_ERASE);
            wrt_ff  <= op_start && (cmd_ff == CMD_WRITE);
            page_ff <= op_start ? spm_target_addr[15:WORD_W] : page_ff;
            bword_ff <= spm_take ? spm_target_addr[WORD_W-1:0] : bword_ff;
            bdata_ff <= spm_take ? spm_data : bdata_ff;
        end
    end

    // *****************************************************************
    // CPU read gate
    // *****************************************************************
    // Fetching the busy region is the CPU's job to avoid; data is masked
    assign cross_rd_ok = (rd_boot == from_boot) ? 1'b1 :
                         (rd_boot ? fuse_ff[4 + LOCK_RD_BIT]
                                  : fuse_ff[2 + LOCK_RD_BIT]);
    assign rd_ok = cross_rd_ok && !(rww_busy_ff && !rd_no_read_while_write_region) && !halt_ff;

    always_ff @(posedge ref_clk) begin
        if (srst) begin
            rd_valid_ff <= 1'b0;
            rd_data_ff  <= 16'h0000;
        end else begin
            rd_valid_ff <= cpu_rd_req && rd_ok;
            rd_data_ff  <= (cpu_rd_req && rd_ok) ? flash_rd_data : 16'h0000;
        end
    end

    // *****************************************************************
    // Register read port
    // *****************************************************************
    logic [7:0] ctrl_view, stat_view;
    assign ctrl_view = {ie_ff, rww_busy_ff, cmd_ff};
    assign stat_view = {4'h0, op_busy, halt_ff, in_prog, state_ff == ST_ARMED};

    always_ff @(posedge ref_clk) begin
        if (srst) begin
            rdata_ff <= 8'h00;
        end else begin
            rdata_ff <= !reg_re ? 8'h00 :
                        (reg_addr == REG_CTRL_ADDR) ? ctrl_view :
                        (reg_addr == REG_STAT_ADDR) ? stat_view : 8'h00;
        end
    end

    assign reg_rdata         = rdata_ff;
    assign cpu_rd_data       = rd_data_ff;
    assign cpu_rd_valid      = rd_valid_ff;
    assign cpu_halt          = halt_ff;
    assign spm_done          = done_ff;
    assign buf_wr_en         = bwr_ff;
    assign buf_word_addr     = bword_ff;
    assign buf_wr_data       = bdata_ff;
    assign buf_clear         = bclr_ff;
    assign flash_erase_start = ers_ff;
    assign flash_write_start = wrt_ff;
    assign flash_page_addr   = page_ff;
    assign rww_read_block    = rww_busy_ff;

    // *****************************************************************
    // Assertions
    // *****************************************************************
    default clocking cb @(posedge ref_clk); endclocking
    default disable iff (srst);

    AST_APP_FETCH_IGNORED: assert property (
        spm_req && !fetch_boot |=> !ers_ff && !wrt_ff && !bwr_ff)
        else $error("store from application part was acted on");
    AST_START_FROM_BOOT: assert property (
        (ers_ff || wrt_ff) |-> $past(spm_req && fetch_boot))
        else $error("programming started without boot fetch");
    AST_BOOT_TARGET: assert property (
        spm_take && fsprw_is_prog(cmd_ff) && tgt_boot && fuse_ff[4]
        |=> (ers_ff == $past(cmd_ff == CMD_ERASE)) && (wrt_ff == $past(cmd_ff == CMD_WRITE)))
        else $error("programming of boot page refused");
    AST_BORDER_FUSE: assert property (
        fuse_ff[1:0] == 2'h3 |-> boot_start == BOOT_START_3)
        else $error("boot border does not follow fuses");
    AST_APP_LOCK: assert property (
        op_start && tgt_in_app |-> fuse_ff[2])
        else $error("application part programmed while locked");
    AST_BOOT_LOCK: assert property (
        op_start && tgt_boot |-> fuse_ff[4])
        else $error("boot part programmed while locked");
    AST_BOOT_IN_NO_READ_WHILE_WRITE_REGION: assert property (
        tgt_boot |-> tgt_no_read_while_write_region)
        else $error("boot part outside halt region");
    AST_RWW_NO_HALT: assert property (
        state_ff == ST_PROG_RWW |-> !halt_ff && rww_busy_ff)
        else $error("rewrite region programming stalled the CPU");
    AST_NO_READ_WHILE_WRITE_REGION_HALT: assert property (
        state_ff == ST_PROG_NO_READ_WHILE_WRITE_REGION |-> halt_ff)
        else $error("CPU ran during halt region programming");
    AST_RWW_READ_MASK: assert property (
        cpu_rd_req && !rd_no_read_while_write_region && rww_busy_ff |=> !rd_valid_ff)
        else $error("rewrite region data returned while busy");
    AST_BUSY_READBACK: assert property (
        reg_re && reg_addr == REG_CTRL_ADDR |=> rdata_ff[CTRL_BUSY_BIT] == $past(rww_busy_ff))
        else $error("busy flag readback wrong");
    AST_RESUME: assert property (
        op_done && state_ff == ST_PROG_NO_READ_WHILE_WRITE_REGION |=> !halt_ff && done_ff)
        else $error("halt not released at completion");
    AST_WINDOW_LAPSE: assert property (
        arm_wr && state_ff == ST_IDLE ##1 (!spm_req && !arm_wr)[*4] |=> state_ff == ST_IDLE)
        else $error("command survived past four cycles");
    AST_BUSY_HOLD: assert property (
        rww_busy_ff && !reen_wr |=> rww_busy_ff)
        else $error("busy flag cleared without software");

    COV_RWW_PROG: cover property (op_start && !tgt_no_read_while_write_region);
    COV_NO_READ_WHILE_WRITE_REGION_PROG: cover property (state_ff == ST_PROG_NO_READ_WHILE_WRITE_REGION ##1 !halt_ff);
    COV_LOAD: cover property (bwr_ff);

endmodule

// *** hdl/fsprw_op_timer.sv ***
`timescale 1ns/1ps
module fsprw_op_timer #(
    parameter int unsigned CYCLES = 400000
) (
    input  wire logic ref_clk,
    input  wire logic srst,
    input  wire logic start,
    output logic      busy,
    output logic      done
);

    // *****************************************************************
    // Programming duration counter
    // *****************************************************************
    logic [31:0] cnt_ff;
    logic [31:0] nxt_cnt;
    logic        done_ff;

    // Restart wins over a running count
    assign nxt_cnt = start ? 32'(CYCLES) :
                     ((cnt_ff != 32'h0) ? (cnt_ff - 32'h1) : 32'h0);
    assign busy    = (cnt_ff != 32'h0);
    assign done    = done_ff;

    // Done pulses once when the count runs out
    always_ff @(posedge ref_clk) begin
        if (srst) begin
            cnt_ff  <= 32'h0;
            done_ff <= 1'b0;
        end else begin
            cnt_ff  <= nxt_cnt;
            done_ff <= (cnt_ff == 32'h1) && !start;
        end
    end

endmodule

// *** hdl/fsprw_pkg.sv ***
package fsprw_pkg;

    // *****************************************************************
    // Flash geometry (word addressed)
    // *****************************************************************
    localparam int unsigned ADDR_W     = 16;
    localparam int unsigned DATA_W     = 16;
    localparam int unsigned WORD_W     = 7;
    localparam int unsigned PAGE_W     = ADDR_W - WORD_W;

    // Fixed border of the region that halts the CPU while programmed
    localparam logic [15:0] NO_READ_WHILE_WRITE_REGION_START = 16'hF000;

    // First word of the boot part for each boot-size fuse value
    localparam logic [15:0] BOOT_START_0 = 16'hF000;
    localparam logic [15:0] BOOT_START_1 = 16'hF800;
    localparam logic [15:0] BOOT_START_2 = 16'hFC00;
    localparam logic [15:0] BOOT_START_3 = 16'hFE00;

    // *****************************************************************
    // Register port
    // *****************************************************************
    localparam logic [7:0] REG_CTRL_ADDR = 8'h00;
    localparam logic [7:0] REG_STAT_ADDR = 8'h01;
    localparam logic [7:0] CTRL_RST      = 8'h00;

    localparam int unsigned CTRL_EN_BIT   = 0;
    localparam int unsigned CTRL_BUSY_BIT = 6;
    localparam int unsigned CTRL_IE_BIT   = 7;

    // Command patterns in control bits 5..0
    localparam logic [5:0] CMD_LOAD  = 6'h01;
    localparam logic [5:0] CMD_ERASE = 6'h03;
    localparam logic [5:0] CMD_WRITE = 6'h05;
    localparam logic [5:0] CMD_REEN  = 6'h11;
    localparam logic [5:0] CMD_NONE  = 6'h00;

    // Lock pair: bit 0 low blocks programming, bit 1 low blocks cross reads
    localparam int unsigned LOCK_WR_BIT = 0;
    localparam int unsigned LOCK_RD_BIT = 1;

    // *****************************************************************
    // Timing
    // *****************************************************************
    localparam int unsigned CLK_MHZ      = 100;
    localparam logic [2:0]  SPM_WIN_CYC  = 3'h4;
    localparam int unsigned PROG_TIME_US = 4000;
    localparam int unsigned PROG_CYC     = PROG_TIME_US * CLK_MHZ;

    // *****************************************************************
    // Sequencer states
    // *****************************************************************
    typedef enum logic [3:0] {
        ST_IDLE      = 4'b0001,
        ST_ARMED     = 4'b0010,
        ST_PROG_RWW  = 4'b0100,
        ST_PROG_NO_READ_WHILE_WRITE_REGION = 4'b1000
    } fsprw_state_type;

endpackage

// *** hdl/fsprw_region_map.sv ***
`timescale 1ns/1ps
module fsprw_region_map
    import fsprw_pkg::*;
(
    input  wire logic [15:0] addr,
    input  wire logic [15:0] boot_start,
    output logic             in_boot,
    output logic             in_no_read_while_write_region
);
    import fsprw_pkg::*;

    // *****************************************************************
    // Address classification
    // *****************************************************************
    // Boot border moves with fuses, the halt border never does
    assign in_boot = (addr >= boot_start);
    assign in_no_read_while_write_region = (addr >= NO_READ_WHILE_WRITE_REGION_START);

endmodule

// *** tb/fsprw_cpu_model.sv ***
`timescale 1ns/1ps
// *****************************************************************
// CPU core and array read port seen by the sequencer
// *****************************************************************
module fsprw_cpu_model (
    input  wire logic   ref_clk,
    output logic        spm_req,
    output logic [15:0] spm_fetch_addr,
    output logic [15:0] spm_target_addr,
    output logic [15:0] spm_data,
    output logic        cpu_rd_req,
    output logic [15:0] cpu_rd_addr,
    output logic [15:0] cpu_rd_from,
    output logic [15:0] flash_rd_data
);
    // Array content is a scramble of the address, so stale data shows
    assign flash_rd_data = cpu_rd_addr ^ 16'hA5A5;

    // Idle lines carry junk, never a value that could pass by luck
    initial begin
        spm_req         = 1'b0;
        cpu_rd_req      = 1'b0;
        spm_fetch_addr  = 16'hDEAD;
        spm_target_addr = 16'hBEEF;
        spm_data        = 16'h5A5A;
        cpu_rd_addr     = 16'hC3C3;
        cpu_rd_from     = 16'h3C3C;
    end

    // Caller opens the window first; this issues the store next cycle
    task automatic store(input logic [15:0] from, input logic [15:0] tgt);
        @(posedge ref_clk);
        spm_req         <= 1'b1;
        spm_fetch_addr  <= from;
        spm_target_addr <= tgt;
        spm_data        <= tgt ^ 16'h1234;
        @(posedge ref_clk);
        spm_req         <= 1'b0;
        spm_fetch_addr  <= ~from;
        spm_target_addr <= ~tgt;
        spm_data        <= ~spm_data;
        #1;
    endtask

    // One read; result lands the cycle after the request
    task automatic fetch(input logic [15:0] addr, input logic [15:0] from);
        @(posedge ref_clk);
        cpu_rd_req  <= 1'b1;
        cpu_rd_addr <= addr;
        cpu_rd_from <= from;
        @(posedge ref_clk);
        cpu_rd_req  <= 1'b0;
        cpu_rd_addr <= ~addr;
        cpu_rd_from <= ~from;
        #1;
    endtask
endmodule

// *** tb/fsprw_ctrl_bench.sv ***
`timescale 1ns/1ps
module fsprw_ctrl_bench;
    import fsprw_pkg::*;
    localparam int unsigned PCYC = 20;
    localparam logic [15:0] BS [4] = '{BOOT_START_0, BOOT_START_1, BOOT_START_2, BOOT_START_3};
    logic ref_clk = 1'b0;
    logic srst = 1'b1;
    logic reg_we = 1'b0;
    logic reg_re = 1'b0;
    logic [7:0] reg_addr = 8'h00;
    logic [7:0] reg_wdata = 8'h00;
    logic [1:0] boot_size_fuses = 2'h0;
    logic [1:0] application_lock_pair = 2'h3;
    logic [1:0] boot_lock_pair = 2'h3;
    logic [7:0] reg_rdata, r;
    logic [15:0] spm_fetch_addr, spm_target_addr, spm_data, cpu_rd_addr, cpu_rd_from;
    logic [15:0] flash_rd_data, cpu_rd_data, buf_wr_data;
    logic spm_req, cpu_rd_req, cpu_rd_valid, cpu_halt, spm_done, buf_wr_en, buf_clear;
    logic flash_erase_start, flash_write_start, rww_read_block;
    logic [6:0] buf_word_addr;
    logic [8:0] flash_page_addr;
    int err_total = 0;
    int compares = 0;
    int cycles = 0;
    int n;

    fsprw_ctrl #(.PROG_CYCLES(PCYC)) i_dut (.*);
    fsprw_cpu_model i_cpu (.*);

    always #5 ref_clk = ~ref_clk;

    // *****************************************************************
    // Bus tasks and checking
    // *****************************************************************
    task automatic check(input string what, input logic [15:0] seen, input logic [15:0] exp);
        compares++;
        if (seen !== exp) begin
            err_total++;
            $display("Error %s expected %h seen %h", what, exp, seen);
        end
    endtask
    task automatic tally_and_finish();
        if (err_total == 0 && compares > 0) begin
            $display("All checks passed");
        end else begin
            $display("Checks failed");
        end
        $finish;
    endtask
    task automatic wr(input logic [7:0] a, input logic [7:0] d);
        @(posedge ref_clk);
        reg_we    <= 1'b1;
        reg_addr  <= a;
        reg_wdata <= d;
        @(posedge ref_clk);
        reg_we    <= 1'b0;
        #1;
    endtask
    task automatic rd(input logic [7:0] a, output logic [7:0] d);
        @(posedge ref_clk);
        reg_re   <= 1'b1;
        reg_addr <= a;
        @(posedge ref_clk);
        reg_re   <= 1'b0;
        #1;
        d = reg_rdata;
    endtask
    // Arm a command, then store from the given place
    task automatic op(input logic [5:0] cmd, input logic [15:0] from, input logic [15:0] tgt);
        wr(REG_CTRL_ADDR, {2'b00, cmd});
        i_cpu.store(from, tgt);
    endtask
    // Poll status until programming ends, bounded
    task automatic wait_idle();
        n = 0;
        do begin
            rd(REG_STAT_ADDR, r);
            n++;
        end while (r[1] !== 1'b0 && n < 40);
        check("prog done", r[1], 1'b0);
    endtask

    // Hang guard, the run needs well under a thousand cycles
    always @(posedge ref_clk) begin
        cycles <= cycles + 1;
        if (cycles == 4000) begin
            err_total++;
            tally_and_finish();
        end
    end

    // *****************************************************************
    // Scenarios
    // *****************************************************************
    initial begin
        repeat (4) @(posedge ref_clk);
        srst <= 1'b0;
        repeat (4) @(posedge ref_clk);
        rd(REG_CTRL_ADDR, r);
        check("ctrl reset", r, CTRL_RST);
        rd(8'h05, r);
        check("unmapped", r, 8'h00);
        // Store just below each boot border is dropped; at the border it runs
        for (int f = 0; f < 4; f++) begin
            boot_size_fuses <= f[1:0];
            repeat (3) @(posedge ref_clk);
            op(CMD_LOAD, BS[f] - 16'h0001, 16'h0083);
            check("app store", buf_wr_en, 1'b0);
            check("app done", spm_done, 1'b1);
            i_cpu.store(BS[f], 16'h0083);
            check("boot store", buf_wr_en, 1'b1);
            check("buf addr", buf_word_addr, 7'h03);
            check("buf data", buf_wr_data, 16'h0083 ^ 16'h1234);
        end
        boot_size_fuses <= 2'h0;
        boot_lock_pair  <= 2'h2;
        repeat (4) @(posedge ref_clk);
        // Store one cycle past the window finds the command lapsed
        wr(REG_CTRL_ADDR, {2'b00, CMD_LOAD});
        repeat (3) @(posedge ref_clk);
        i_cpu.store(16'hF000, 16'h0083);
        check("late store", buf_wr_en, 1'b0);
        rd(REG_STAT_ADDR, r);
        check("lapsed", r[0], 1'b0);
        // Erase in the rewrite region with the boot part locked
        op(CMD_ERASE, 16'hF000, 16'h0280);
        check("erase start", flash_erase_start, 1'b1);
        check("page", flash_page_addr, 9'h005);
        check("no halt", cpu_halt, 1'b0);
        rd(REG_CTRL_ADDR, r);
        check("busy bit", r[CTRL_BUSY_BIT], 1'b1);
        i_cpu.fetch(16'h0100, 16'hF000);
        check("blocked valid", cpu_rd_valid, 1'b0);
        i_cpu.fetch(16'hF100, 16'hF000);
        check("no_read_while_write_region valid", cpu_rd_valid, 1'b1);
        check("no_read_while_write_region data", cpu_rd_data, 16'hF100 ^ 16'hA5A5);
        wait_idle();
        check("busy held", rww_read_block, 1'b1);
        wr(REG_CTRL_ADDR, {2'b00, CMD_REEN});
        check("buf clear", buf_clear, 1'b1);
        check("busy clear", rww_read_block, 1'b0);
        i_cpu.fetch(16'h0100, 16'h0200);
        check("rww data", cpu_rd_data, 16'h0100 ^ 16'hA5A5);
        op(CMD_ERASE, 16'hF000, 16'hF800);
        check("boot locked", flash_erase_start, 1'b0);
        check("locked done", spm_done, 1'b1);
        application_lock_pair <= 2'h2;
        boot_lock_pair        <= 2'h3;
        repeat (4) @(posedge ref_clk);
        op(CMD_ERASE, 16'hF000, 16'h0100);
        check("app locked", flash_erase_start, 1'b0);
        application_lock_pair <= 2'h3;
        repeat (4) @(posedge ref_clk);
        // Page write into the boot part itself stalls the core
        op(CMD_WRITE, 16'hF000, 16'hF080);
        check("write start", flash_write_start, 1'b1);
        check("halt", cpu_halt, 1'b1);
        check("no early done", spm_done, 1'b0);
        n = 0;
        // Halted core issues nothing, so no fetch here
        while (cpu_halt === 1'b1 && n < 100) begin
            @(posedge ref_clk);
            #1;
            n++;
        end
        check("halt length", 16'(n >= PCYC && n <= PCYC + 3), 1'b1);
        check("resume", spm_done, 1'b1);
        check("no block", rww_read_block, 1'b0);
        tally_and_finish();
    end
endmodule
